// *** hw/spd_pkg.sv ***
// Constants, code tables and coding functions of the PCS datapath
package spd_pkg;

  // ************************************************************
  // Widths and counts
  // ************************************************************
  localparam int WORD_W = 10;
  localparam int ENTRY_W = 20;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] FIFO_DEPTH = 4'h8;
  localparam logic [3:0] CTC_HIGH = 4'h6;
  localparam logic [3:0] PTR_ONE = 4'h1;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] LAST10 = 4'h9;
  localparam logic [3:0] LAST8 = 4'h7;
  localparam logic [9:0] WORD_ZERO = 10'h000;
  // Bits before the comma window holds only line data: sync stages plus ten
  localparam logic [3:0] RX_PRIME = 4'hC;

  // ************************************************************
  // Comma and special characters
  // ************************************************************
  localparam logic [6:0] COMMA_POS = 7'h1F;
  localparam logic [6:0] COMMA_NEG = 7'h60;
  localparam logic [7:0] SKIP_CHAR = 8'h1C;
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [4:0] K28_IDX = 5'h1C;
  localparam logic [4:0] D7_IDX = 5'h07;
  localparam logic [2:0] D3_IDX = 3'h3;
  localparam logic [2:0] ALT_IDX = 3'h7;
  localparam logic [3:0] ALT4 = 4'h7;
  localparam int BAL6 = 3;
  localparam int BAL4 = 2;
  localparam logic [31:0] ALT_NEG_MASK = 32'h00160000;
  localparam logic [31:0] ALT_POS_MASK = 32'h00006800;

  // Negative-disparity forms; positive forms of unbalanced codes, D.7 and D.x.3 are their complements
  localparam logic [5:0] TBL6 [32] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] TBL4 [8] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  typedef enum logic {ALIGN_SEARCH, ALIGN_LOCKED} spd_align_e;

  // ************************************************************
  // 8b/10b encode: returns {running disparity out, abcdei fghj}
  // ************************************************************
  function automatic logic [10:0] spd_encode(input logic [7:0] d,
      input logic k, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] code;
    logic r;
    logic k28;
    logic alt;
    k28 = k && (d[4:0] == K28_IDX);
    // K28 codes are built from negative disparity, then flipped if the running disparity is positive
    r = k28 ? 1'b0 : rd;
    c6 = k28 ? K28_6B : TBL6[d[4:0]];
    if (r && (($countones(c6) != BAL6) || (d[4:0] == D7_IDX) && !k28))
      c6 = ~c6;
    if ($countones(c6) != BAL6)
      r = ~r;
    alt = (d[7:5] == ALT_IDX) && (k28 || (!r && ALT_NEG_MASK[d[4:0]]) ||
          (r && ALT_POS_MASK[d[4:0]]));
    c4 = alt ? ALT4 : TBL4[d[7:5]];
    if (r && (($countones(c4) != BAL4) || (d[7:5] == D3_IDX)))
      c4 = ~c4;
    if ($countones(c4) != BAL4)
      r = ~r;
    code = {c6, c4};
    if (k28 && rd)
      code = ~code;
    return {k28 ? (r ^ rd) : r, code};
  endfunction : spd_encode

  // ************************************************************
  // 8b/10b decode: returns {code error, control flag, data}
  // ************************************************************
  function automatic logic [9:0] spd_decode(input logic [9:0] w);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [4:0] d5;
    logic [2:0] d3;
    logic hit6;
    logic hit4;
    logic k28p;
    logic k28n;
    c6 = w[9:4];
    d5 = '0;
    d3 = '0;
    hit6 = 1'b0;
    hit4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (c6 == TBL6[i] || (c6 == ~TBL6[i] &&
          (($countones(TBL6[i]) != BAL6) || 5'(i) == D7_IDX))) begin
        d5 = 5'(i);
        hit6 = 1'b1;
      end
    end
    k28p = (c6 == K28_6B);
    k28n = (c6 == ~K28_6B);
    if (k28p || k28n) begin
      d5 = K28_IDX;
      hit6 = 1'b1;
    end
    // A control code from positive disparity is wholly complemented
    c4 = k28n ? ~w[3:0] : w[3:0];
    for (int j = 0; j < 8; j++) begin
      if (c4 == TBL4[j] || (c4 == ~TBL4[j] &&
          (($countones(TBL4[j]) != BAL4) || 3'(j) == D3_IDX))) begin
        d3 = 3'(j);
        hit4 = 1'b1;
      end
    end
    if (c4 == ALT4 || c4 == ~ALT4) begin
      d3 = ALT_IDX;
      hit4 = 1'b1;
    end
    return {!(hit6 && hit4), k28p || k28n, d3, d5};
  endfunction : spd_decode

endpackage : spd_pkg

// *** hw/spd_fifo_mem.sv ***
// Storage of the down-sample FIFO with a registered read port
module spd_fifo_mem (
  input logic clk,
  input logic reset,
  input logic wrEn,
  input logic [spd_pkg::FIFO_AW-1:0] wrAddr,
  input logic [spd_pkg::ENTRY_W-1:0] wrData,
  input logic rdEn,
  input logic [spd_pkg::FIFO_AW-1:0] rdAddr,
  output logic [spd_pkg::ENTRY_W-1:0] rdData
);
  import spd_pkg::*;

  logic [ENTRY_W-1:0] mem [2**FIFO_AW];
  logic [ENTRY_W-1:0] next_rdData;

  // Array has no reset; only entries already written are ever read
  always_ff @(posedge clk) begin
    if (wrEn)
      mem[wrAddr] <= wrData;
  end

  // Read data holds until the next read
  always_comb begin
    next_rdData = rdEn ? mem[rdAddr] : rdData;
  end

  always_ff @(posedge clk) begin
    if (reset)
      rdData <= '0;
    else
      rdData <= next_rdData;
  end
endmodule : spd_fifo_mem

// *** hw/spd_datapath.sv ***
// Serial PCS datapath: deserializer, aligner, coder, FIFO, serializer
//
// Functional notes
// - Receive order: polarity, alignment, decode, compensation
// - Down-sample FIFO after compensation feeds core
// - Transmit: encode, polarity, then serializer
// - Bypass passes raw 8 or 10-bit words
// - Half rate pairs two words per transfer
// - Incoming bits become parallel words
// - Parallel words are shifted out serially
// - Receive and transmit word timing offered
module spd_datapath (
  input logic clk,
  input logic reset,
  input logic rxSerialIn,
  input logic rxInvert,
  input logic txInvert,
  input logic bypassCoding,
  input logic width8,
  input logic halfRate,
  input logic coreRxReady,
  input logic [spd_pkg::ENTRY_W-1:0] coreTxData,
  input logic [1:0] coreTxK,
  output logic txSerialOut,
  output logic txDataReq,
  output logic txWordTick,
  output logic rxWordTick,
  output logic rxAligned,
  output logic [spd_pkg::ENTRY_W-1:0] coreRxData,
  output logic coreRxValid,
  output logic rxOverflow,
  output logic rxSkipDropped
);
  import spd_pkg::*;

  // Last bit index of a word in the current mode
  function automatic logic [3:0] wordLast(input logic byp,
      input logic w8);
    return (byp && w8) ? LAST8 : LAST10;
  endfunction : wordLast

  // ************************************************************
  // Receive: synchroniser, deserializer and aligner
  // ************************************************************
  logic syncA;
  logic syncB;
  logic [9:0] rxShift, next_rxShift, nShift;
  logic [3:0] rxCnt, next_rxCnt, rxLast, rxFill, next_rxFill;
  spd_align_e alignState, next_alignState;
  logic wide8, commaHit, wordDone, deliver, isSkip;
  logic [9:0] decWord, payload;
  logic next_rxWordTick, next_rxAligned;

  // Serial pin passes two flops before anything looks at it
  always_ff @(posedge clk) begin
    if (reset) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end else begin
      syncA <= rxSerialIn;
      syncB <= syncA;
    end
  end

  // Bit assembly; the comma window is the newest ten bits
  always_comb begin
    wide8 = bypassCoding && width8;
    rxLast = wordLast(bypassCoding, width8);
    nShift = {rxShift[8:0], syncB ^ rxInvert};
    // Reset fill of the sync flops and window is not line data and can
    // mimic a comma, so the search waits until the window is primed
    next_rxFill = (rxFill == RX_PRIME) ? rxFill : rxFill + CNT_ONE;
    commaHit = !wide8 && (rxFill == RX_PRIME) &&
               (nShift[9:3] == COMMA_POS || nShift[9:3] == COMMA_NEG);
    next_rxShift = nShift;
    next_rxCnt = rxCnt + CNT_ONE;
    next_alignState = alignState;
    wordDone = 1'b0;
    case (alignState)
      ALIGN_SEARCH: begin
        if (commaHit) begin
          next_alignState = ALIGN_LOCKED;
          next_rxCnt = '0;
          wordDone = 1'b1;
        end else if (rxCnt >= rxLast) begin
          next_rxCnt = '0;
          wordDone = 1'b1;
        end
      end
      ALIGN_LOCKED: begin
        // Boundary stays fixed; later commas are not re-checked
        if (rxCnt >= rxLast) begin
          next_rxCnt = '0;
          wordDone = 1'b1;
        end
      end
      default: begin
        next_alignState = ALIGN_SEARCH;
      end
    endcase
    // Unaligned 10-bit words would be garbage, so they are withheld
    deliver = wordDone && (wide8 || next_alignState == ALIGN_LOCKED);
    decWord = spd_decode(nShift);
    if (bypassCoding)
      payload = wide8 ? {2'h0, nShift[7:0]} : nShift;
    else
      payload = decWord;
    isSkip = !bypassCoding && (decWord == {2'b01, SKIP_CHAR});
    next_rxWordTick = wordDone;
    next_rxAligned = (next_alignState == ALIGN_LOCKED);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rxShift <= '0;
      rxFill <= '0;
      rxCnt <= '0;
      alignState <= ALIGN_SEARCH;
      rxAligned <= 1'b0;
      rxWordTick <= 1'b0;
    end else begin
      rxShift <= next_rxShift;
      rxCnt <= next_rxCnt;
      alignState <= next_alignState;
      rxFill <= next_rxFill;
      rxAligned <= next_rxAligned;
      rxWordTick <= next_rxWordTick;
    end
  end

  // ************************************************************
  // Receive: clock tolerance compensation and down-sample FIFO
  // ************************************************************
  logic pairHalf, next_pairHalf;
  logic [9:0] lowHold, next_lowHold;
  logic [3:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr, fill;
  logic wrReq, doWrite, rdEn, dropSkip, full;
  logic [ENTRY_W-1:0] wrData;
  logic next_coreRxValid, next_rxOverflow, next_rxSkipDropped;

  // Skips are dropped only when the core falls behind
  always_comb begin
    fill = wrPtr - rdPtr;
    full = (fill == FIFO_DEPTH);
    dropSkip = deliver && isSkip && (fill >= CTC_HIGH);
    next_pairHalf = halfRate ? pairHalf : 1'b0;
    next_lowHold = lowHold;
    wrReq = 1'b0;
    wrData = {WORD_ZERO, payload};
    if (deliver && !dropSkip) begin
      if (halfRate && !pairHalf) begin
        next_lowHold = payload;
        next_pairHalf = 1'b1;
      end else begin
        wrReq = 1'b1;
        wrData = halfRate ? {payload, lowHold} : {WORD_ZERO, payload};
        next_pairHalf = 1'b0;
      end
    end
    doWrite = wrReq && !full;
    rdEn = (fill != '0) && coreRxReady;
    next_wrPtr = doWrite ? wrPtr + PTR_ONE : wrPtr;
    next_rdPtr = rdEn ? rdPtr + PTR_ONE : rdPtr;
    next_coreRxValid = rdEn;
    next_rxOverflow = wrReq && full;
    next_rxSkipDropped = dropSkip;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pairHalf <= 1'b0;
      lowHold <= '0;
      wrPtr <= '0;
      rdPtr <= '0;
      coreRxValid <= 1'b0;
      rxOverflow <= 1'b0;
      rxSkipDropped <= 1'b0;
    end else begin
      pairHalf <= next_pairHalf;
      lowHold <= next_lowHold;
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      coreRxValid <= next_coreRxValid;
      rxOverflow <= next_rxOverflow;
      rxSkipDropped <= next_rxSkipDropped;
    end
  end

  // Read data is a register inside the memory
  spd_fifo_mem fifoMem (
    .clk(clk),
    .reset(reset),
    .wrEn(doWrite),
    .wrAddr(wrPtr[FIFO_AW-1:0]),
    .wrData(wrData),
    .rdEn(rdEn),
    .rdAddr(rdPtr[FIFO_AW-1:0]),
    .rdData(coreRxData)
  );

  // ************************************************************
  // Transmit: encoder, polarity and serializer
  // ************************************************************
  logic [9:0] txShift, next_txShift, txHiHold, next_txHiHold, srcWord;
  logic [3:0] txCnt, next_txCnt, txLast;
  logic txRd, next_txRd, txSecond, next_txSecond;
  logic txHiK, next_txHiK, srcK, load;
  logic [10:0] enc;
  logic next_txDataReq, next_txWordTick;

  // Word is loaded on the last bit slot; MSB leaves first
  always_comb begin
    txLast = wordLast(bypassCoding, width8);
    load = (txCnt >= txLast);
    next_txCnt = load ? '0 : txCnt + CNT_ONE;
    srcWord = txSecond ? txHiHold : coreTxData[9:0];
    srcK = txSecond ? txHiK : coreTxK[0];
    enc = spd_encode(srcWord[7:0], srcK, txRd);
    next_txShift = {txShift[8:0], 1'b0};
    next_txRd = txRd;
    next_txSecond = txSecond;
    next_txHiHold = txHiHold;
    next_txHiK = txHiK;
    if (load) begin
      if (bypassCoding && width8)
        next_txShift = {srcWord[7:0] ^ {8{txInvert}}, 2'h0};
      else if (bypassCoding)
        next_txShift = srcWord ^ {10{txInvert}};
      else begin
        next_txShift = enc[9:0] ^ {10{txInvert}};
        next_txRd = enc[10];
      end
      if (halfRate && !txSecond) begin
        next_txHiHold = coreTxData[19:10];
        next_txHiK = coreTxK[1];
        next_txSecond = 1'b1;
      end else begin
        next_txSecond = 1'b0;
      end
    end
    // Request marks the cycle in which core data is sampled
    next_txDataReq = (next_txCnt >= txLast) && !next_txSecond;
    next_txWordTick = load;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      txShift <= '0;
      txCnt <= '0;
      txRd <= 1'b0;
      txSecond <= 1'b0;
      txHiHold <= '0;
      txHiK <= 1'b0;
      txDataReq <= 1'b0;
      txWordTick <= 1'b0;
    end else begin
      txShift <= next_txShift;
      txCnt <= next_txCnt;
      txRd <= next_txRd;
      txSecond <= next_txSecond;
      txHiHold <= next_txHiHold;
      txHiK <= next_txHiK;
      txDataReq <= next_txDataReq;
      txWordTick <= next_txWordTick;
    end
  end

  assign txSerialOut = txShift[9];
endmodule : spd_datapath

// *** sim/spd_datapath_sva.sv ***
// Port timing checker for the PCS datapath
module spd_datapath_sva (
  input logic clk,
  input logic reset,
  input logic bypassCoding,
  input logic width8,
  input logic halfRate,
  input logic coreRxReady,
  input logic txDataReq,
  input logic txWordTick,
  input logic rxWordTick,
  input logic rxAligned,
  input logic [spd_pkg::ENTRY_W-1:0] coreRxData,
  input logic coreRxValid,
  input logic rxSkipDropped
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic mode8;
  // Short words only in raw 8-bit mode
  assign mode8 = bypassCoding && width8;
  a_txreq_spacing:
  assert property (txDataReq && !halfRate && !mode8 |=>
    !txDataReq [*8] ##1 !txDataReq ##1 txDataReq) else $error("tx req gap");
  a_tick_follows:
  assert property (txDataReq |=> txWordTick) else $error("tx tick late");
  a_txtick_period:
  assert property (txWordTick && !mode8 |=>
    !txWordTick [*8] ##1 !txWordTick ##1 txWordTick) else $error("tx tick");
  a_rxtick_period:
  assert property (rxAligned && rxWordTick |=>
    !rxWordTick [*8] ##1 !rxWordTick ##1 rxWordTick) else $error("rx tick");
  a_lock_on_tick:
  assert property ($rose(rxAligned) |-> rxWordTick) else $error("lock tick");
  a_valid_after_ready:
  assert property (coreRxValid |-> $past(coreRxReady)) else $error("no ready");
  a_valid_locked:
  assert property (coreRxValid && !mode8 |-> rxAligned) else $error("unlocked");
  a_upper_zero:
  assert property (coreRxValid && !halfRate |-> coreRxData[19:10] == 10'h000)
    else $error("upper word set");
  a_skip_coded:
  assert property (rxSkipDropped |-> !bypassCoding) else $error("raw skip");
endmodule : spd_datapath_sva

bind spd_datapath spd_datapath_sva u_sva (.clk(clk), .reset(reset),
  .bypassCoding(bypassCoding), .width8(width8), .halfRate(halfRate),
  .coreRxReady(coreRxReady), .txDataReq(txDataReq), .txWordTick(txWordTick),
  .rxWordTick(rxWordTick), .rxAligned(rxAligned), .coreRxData(coreRxData),
  .coreRxValid(coreRxValid), .rxSkipDropped(rxSkipDropped));

// *** sim/spd_remote_model.sv ***
// Far transceiver: returns the line one bit later
module spd_remote_model (
  input logic clk,
  input logic txLine,
  input logic flipLine,
  output logic rxLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // A swapped pair inverts every bit, as a miswired board would
  always @(posedge clk) rxLine <= txLine ^ flipLine;
endmodule : spd_remote_model

// *** sim/test_spd_datapath.sv ***
// Loopback testbench of the PCS datapath
module test_spd_datapath;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, rxSerialIn, rxInvert, txInvert, bypassCoding, width8;
  logic halfRate, coreRxReady, txSerialOut, txDataReq, txWordTick;
  logic rxWordTick, rxAligned, coreRxValid, rxOverflow, rxSkipDropped;
  logic lineFlip, skipSeen, ovfSeen;
  logic [19:0] coreTxData, coreRxData;
  logic [1:0] coreTxK;
  logic [21:0] txq [16];
  logic [21:0] idleWord;
  logic [19:0] rxq [$];
  logic [9:0] wireSh, firstWord;
  int txLen, txIdx, nxt, ticks, err_total, cmp_count;

  spd_datapath dut (.clk(clk), .reset(reset), .rxSerialIn(rxSerialIn),
    .rxInvert(rxInvert), .txInvert(txInvert), .bypassCoding(bypassCoding),
    .width8(width8), .halfRate(halfRate), .coreRxReady(coreRxReady),
    .coreTxData(coreTxData), .coreTxK(coreTxK), .txSerialOut(txSerialOut),
    .txDataReq(txDataReq), .txWordTick(txWordTick),
    .rxWordTick(rxWordTick), .rxAligned(rxAligned),
    .coreRxData(coreRxData), .coreRxValid(coreRxValid),
    .rxOverflow(rxOverflow), .rxSkipDropped(rxSkipDropped));
  spd_remote_model far (.clk(clk), .txLine(txSerialOut),
    .flipLine(lineFlip), .rxLine(rxSerialIn));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Feed the next word after each sampling edge; collect what comes back
  always @(posedge clk) begin
    nxt = reset ? 0 : txIdx + int'(txDataReq);
    txIdx <= nxt;
    {coreTxK, coreTxData} <= (nxt < txLen) ? txq[nxt] : idleWord;
    wireSh <= {wireSh[8:0], txSerialOut};
    if (reset) begin
      rxq.delete();
      {skipSeen, ovfSeen} <= 2'b00;
      ticks <= 0;
    end else begin
      if (coreRxValid) rxq.push_back(coreRxData);
      if (rxSkipDropped) skipSeen <= 1'b1;
      if (rxOverflow) ovfSeen <= 1'b1;
      if (txWordTick) ticks <= ticks + 1;
      if (txWordTick && ticks == 1) firstWord <= wireSh;
    end
  end

  function automatic logic [21:0] fw(input logic k, input logic [7:0] d);
    return {1'b0, k, 12'h000, d};
  endfunction : fw

  function automatic logic [19:0] dw(input logic k, input logic [7:0] d);
    return {11'h000, k, d};
  endfunction : dw

  // Drives land on the edge; reads see the values settled before it
  task automatic step;
    @(posedge clk);
  endtask : step

  task automatic chk(input logic [19:0] got, input logic [19:0] exp,
      input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // Modes are {bypass, width8, half, txInv, rxInv, lineFlip}
  task automatic start(input logic [5:0] m);
    step();
    {bypassCoding, width8, halfRate, txInvert, rxInvert, lineFlip} <= m;
    reset <= 1'b1;
    repeat (8) step();
    reset <= 1'b0;
  endtask : start

  task automatic waitq(input int n);
    for (int i = 0; i < 3000 && rxq.size() < n; i++) step();
    chk(20'(rxq.size() >= n), 20'h1, "rx count");
  endtask : waitq

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Coded loopback, inverting on one side and undoing it on the other
  task automatic t_coded;
    logic [7:0] d [7] = '{8'hBC, 8'h00, 8'hFF, 8'hA5, 8'hF1, 8'h7C, 8'h1C};
    logic [6:0] kb = 7'b1100001;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 7; i++) txq[i] = fw(kb[i], d[i]);
      txLen = 7;
      idleWord = fw(1'b1, 8'hBC);
      start({3'b000, p[0], !p[0], 1'b1});
      waitq(7);
      chk(20'(firstWord), p ? 20'h305 : 20'h0FA, "comma on wire");
      chk(20'(rxAligned), 20'h1, "lock");
      for (int i = 0; i < 7; i++) chk(rxq[i], dw(kb[i], d[i]), "dec");
    end
    $display("coded loopback done");
  endtask : t_coded

  task automatic t_raw10;
    logic [9:0] r [4] = '{10'h0FA, 10'h155, 10'h2AA, 10'h0F0};
    for (int i = 0; i < 4; i++) txq[i] = {12'h000, r[i]};
    txLen = 4;
    idleWord = 22'h0000FA;
    start(6'b100000);
    waitq(4);
    chk(20'(firstWord), 20'h0FA, "raw wire");
    for (int i = 0; i < 4; i++) chk(rxq[i], {10'h000, r[i]}, "raw");
    $display("raw 10-bit done");
  endtask : t_raw10

  task automatic t_half;
    txq[0] = {2'b01, 2'b00, 8'h5A, 2'b00, 8'hBC};
    txq[1] = {2'b10, 2'b00, 8'h7C, 2'b00, 8'h33};
    txLen = 2;
    idleWord = {2'b11, 10'h0BC, 10'h0BC};
    start(6'b001000);
    waitq(2);
    chk(rxq[0], {10'(dw(0, 8'h5A)), 10'(dw(1, 8'hBC))}, "pair 0");
    chk(rxq[1], {10'(dw(1, 8'h7C)), 10'(dw(0, 8'h33))}, "pair 1");
    $display("half rate done");
  endtask : t_half

  task automatic t_raw8;
    int n;
    txLen = 0;
    idleWord = 22'h00003C;
    start(6'b110000);
    for (n = 0; n < 100 && txDataReq !== 1'b1; n++) step();
    step();
    n = 1;
    while (n < 40 && txDataReq !== 1'b1) begin
      step();
      n++;
    end
    chk(20'(n), 20'h8, "8-bit period");
    waitq(1);
    chk(20'(rxq[0][19:8]), 20'h0, "8-bit entry");
    $display("raw 8-bit done");
  endtask : t_raw8

  // Core stalls: skip codes go at the high mark, then the FIFO overflows
  task automatic t_ctc;
    logic [7:0] d [11] = '{8'hBC, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h1C,
      8'h1C, 8'h06, 8'h07, 8'h08};
    logic [10:0] kb = 11'b00011000001;
    for (int i = 0; i < 11; i++) txq[i] = fw(kb[i], d[i]);
    txLen = 11;
    idleWord = fw(1'b1, 8'hBC);
    coreRxReady <= 1'b0;
    start(6'b000000);
    for (int i = 0; i < 2000 && ovfSeen !== 1'b1; i++) step();
    chk(20'(skipSeen), 20'h1, "skip dropped");
    chk(20'(ovfSeen), 20'h1, "overflow");
    chk(20'(rxq.size()), 20'h0, "held while stalled");
    coreRxReady <= 1'b1;
    waitq(8);
    for (int i = 0; i < 8; i++)
      chk(rxq[i], dw(kb[i < 6 ? i : i + 2], d[i < 6 ? i : i + 2]), "fifo");
    $display("compensation and overflow done");
  endtask : t_ctc

  initial begin
    {reset, coreRxReady} = 2'b11;
    {rxInvert, txInvert, bypassCoding, width8, halfRate, lineFlip} = 6'h00;
    {idleWord, txLen} = '0;
    t_coded();
    t_raw10();
    t_half();
    t_raw8();
    t_ctc();
    print_verdict();
  end

  // Six short runs take well under this span
  initial begin
    #400000;
    err_total++;
    print_verdict();
  end
endmodule : test_spd_datapath
